// ---- src/ee_pkg.sv ----
// shared constants, state codes and pin bundle of the serial memory slave
package ee_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 8;

  // self-timed programming limit in milliseconds
  localparam int PROG_TIME_MS = 5;
  localparam int NS_PER_MS = 1000000;
  // longest time rounds down to whole cycles
  localparam int PROG_CYCLES = (PROG_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;

  // array organisation
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_OFF_W = 6;
  localparam int ADDR_W_SMALL = 14;
  localparam int ADDR_W_LARGE = 15;

  // device address word layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_RW_BIT = 0;

  // bit counting within a word
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // byte position within a write command
  localparam logic [1:0] IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] PROG_CNT_RST = 32'h0000_0000;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_DEV    = 7'h02,
    ST_RX     = 7'h04,
    ST_ACK    = 7'h08,
    ST_TX     = 7'h10,
    ST_TX_ACK = 7'h20,
    ST_WAIT   = 7'h40
  } ee_state_e;

  // pin levels as they pass the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic inhibit;
    logic [2:0] straps;
  } ee_pins_s;

  // synchroniser reset state matches idle lines, so no false edge follows reset
  localparam ee_pins_s PINS_RST = '{scl: 1'b1, sda: 1'b1, inhibit: 1'b0, straps: 3'h0};

endpackage

// ---- src/ee_slave.sv ----
// two-wire serial memory slave: protocol engine, page buffer, programming timer
`timescale 1ns/100ps

// Behaviour
// - sample SDA at SCL rise, change driven SDA only after SCL fall
// - unconnected chip-select straps count as low
// - program-inhibit high blocks all programming; reads unaffected
// - 64-byte pages, 14 or 15 bit byte address per variant
// - SDA fall while SCL high is START, opening every command
// - SDA rise while SCL high is STOP; standby after read or programming
// - acknowledge each received word by pulling SDA low on 9th clock
// - standby after power-up, read STOP, and end of programming
// - device address word must start with type pattern 1010
// - strap bits compared; match acknowledges, mismatch returns to standby
// - eighth address bit high selects read, low selects write
// - byte write: two address bytes then one data byte, each acknowledged
// - STOP closing a write starts the self-timed programming cycle
// - during programming the device ignores inputs and stays silent
// - programming completes within five milliseconds
// - page write accepts up to 63 further acknowledged data bytes
// - only low six address bits increment; excess bytes wrap in page
// - partial page writes program only bytes received
// - no acknowledge while programming; normal acknowledge afterwards for polling
// - SDA is open-drain: only pulled low or released
// - address counter holds last address plus one; current read uses it
// - controller acknowledge requests next sequential byte; no acknowledge ends
// - read address counter wraps past highest address to zero
// - dummy write then new START: random read, pending write dropped
module ee_slave
  import ee_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_LARGE,
  parameter int PROG_LEN = PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] chip_select_straps,
  input wire logic prog_inhibit,
  output logic standby,
  output logic prog_busy
);

  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int PAGE_W = ADDR_W - PAGE_OFF_W;

  // link side: one flop, SDA captured on the rising SCL edge
  logic link_bit_reg;

  // pin synchroniser and edge history
  ee_pins_s pins_raw;
  ee_pins_s sync1_reg;
  ee_pins_s sync2_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic evt_start;
  logic evt_stop;

  // protocol engine
  ee_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte;
  logic [7:0] tx_reg;
  logic [7:0] rd_byte;
  logic [1:0] byte_idx_reg;
  logic [7:0] addr_hi_reg;
  logic [ADDR_W-1:0] addr_cnt_reg;
  logic [PAGE_OFF_W-1:0] page_off_reg;
  logic rw_reg;
  logic data_seen_reg;
  logic load_reg;
  logic sda_oe_reg;
  logic dev_match;
  logic prog_ok;
  logic [15:0] addr_full;

  // page buffer and array
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_reg;
  logic [7:0] mem [MEM_BYTES];

  // programming timer
  logic prog_start_reg;
  logic busy_reg;
  logic [31:0] prog_cnt_reg;
  logic [PAGE_OFF_W-1:0] prog_idx;

  // outputs
  logic standby_reg;
  logic sda_out_reg;

  // stable from this rise until the next one, so the system side may read
  // it once it has seen the synchronised rise
  always_ff @(posedge scl) begin
    link_bit_reg <= sda_in;
  end

  // pads carry pull-downs, so a floating strap arrives here as low
  assign pins_raw = '{scl: scl, sda: sda_in, inhibit: prog_inhibit,
                      straps: chip_select_straps};

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= PINS_RST;
      sync2_reg <= PINS_RST;
      scl_d_reg <= PINS_RST.scl;
      sda_d_reg <= PINS_RST.sda;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg.scl;
      sda_d_reg <= sync2_reg.sda;
    end
  end

  assign scl_rise = sync2_reg.scl & ~scl_d_reg;
  assign scl_fall = ~sync2_reg.scl & scl_d_reg;
  assign evt_start = sync2_reg.scl & scl_d_reg & sda_d_reg & ~sync2_reg.sda;
  assign evt_stop = sync2_reg.scl & scl_d_reg & ~sda_d_reg & sync2_reg.sda;

  assign rx_byte = {shift_reg[6:0], link_bit_reg};
  assign dev_match = (rx_byte[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE) &&
                     (rx_byte[DEV_SEL_MSB:DEV_SEL_LSB] == sync2_reg.straps);
  // full 16-bit address; bits beyond the array width drop out where the counter loads
  assign addr_full = {addr_hi_reg, rx_byte};
  assign rd_byte = mem[addr_cnt_reg];
  assign prog_ok = data_seen_reg & ~rw_reg & ~sync2_reg.inhibit;

  // protocol engine; START and STOP take priority over bit edges
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= BIT_CNT_RST;
      shift_reg <= BYTE_RST;
      tx_reg <= BYTE_RST;
      byte_idx_reg <= IDX_ADDR_HI;
      addr_hi_reg <= BYTE_RST;
      addr_cnt_reg <= '0;
      page_off_reg <= '0;
      rw_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      load_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      prog_start_reg <= 1'b0;
      page_mask_reg <= '0;
    end else begin
      prog_start_reg <= 1'b0;
      if (busy_reg) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (evt_start) begin
        // a repeated START drops any pending write data
        state_reg <= ST_DEV;
        bit_cnt_reg <= BIT_CNT_RST;
        sda_oe_reg <= 1'b0;
        data_seen_reg <= 1'b0;
        load_reg <= 1'b0;
        page_mask_reg <= '0;
      end else if (evt_stop) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        prog_start_reg <= prog_ok;
        data_seen_reg <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          ST_DEV: begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              if (dev_match) begin
                rw_reg <= rx_byte[DEV_RW_BIT];
                byte_idx_reg <= IDX_ADDR_HI;
                state_reg <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_RX: begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= ST_ACK;
              case (byte_idx_reg)
                IDX_ADDR_HI: begin
                  addr_hi_reg <= rx_byte;
                  byte_idx_reg <= IDX_ADDR_LO;
                end
                IDX_ADDR_LO: begin
                  addr_cnt_reg <= addr_full[ADDR_W-1:0];
                  page_off_reg <= rx_byte[PAGE_OFF_W-1:0];
                  byte_idx_reg <= IDX_DATA;
                end
                default: begin
                  // excess bytes wrap over earlier ones in the same page
                  page_buf[page_off_reg] <= rx_byte;
                  page_mask_reg[page_off_reg] <= 1'b1;
                  page_off_reg <= page_off_reg + 6'h01;
                  addr_cnt_reg <= {addr_cnt_reg[ADDR_W-1:PAGE_OFF_W],
                                   page_off_reg + 6'h01};
                  data_seen_reg <= 1'b1;
                end
              endcase
            end
          end
          ST_TX: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= ST_TX_ACK;
            end
          end
          ST_TX_ACK: begin
            if (!link_bit_reg) begin
              load_reg <= 1'b1;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          ST_ACK: begin
            if (!sda_oe_reg) begin
              sda_oe_reg <= 1'b1;
            end else if (rw_reg) begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              addr_cnt_reg <= addr_cnt_reg + 1'b1;
              bit_cnt_reg <= BIT_CNT_RST;
              state_reg <= ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= BIT_CNT_RST;
              state_reg <= ST_RX;
            end
          end
          ST_TX: begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= ~tx_reg[6];
          end
          ST_TX_ACK: begin
            if (load_reg) begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              addr_cnt_reg <= addr_cnt_reg + 1'b1;
              bit_cnt_reg <= BIT_CNT_RST;
              load_reg <= 1'b0;
              state_reg <= ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // self-timed programming; the page is copied in the first 64 cycles
  assign prog_idx = prog_cnt_reg[PAGE_OFF_W-1:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= PROG_CNT_RST;
    end else if (prog_start_reg) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= PROG_CNT_RST;
    end else if (busy_reg) begin
      prog_cnt_reg <= prog_cnt_reg + 32'h1;
      if (prog_cnt_reg == 32'(PROG_LEN - 1)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // array holds no reset; contents survive like the real cells
  always_ff @(posedge clock) begin
    if (busy_reg && prog_cnt_reg < 32'(PAGE_BYTES) && page_mask_reg[prog_idx]) begin
      mem[{addr_cnt_reg[ADDR_W-1:PAGE_OFF_W], prog_idx}] <= page_buf[prog_idx];
    end
  end

  // output flops
  always_ff @(posedge clock) begin
    if (rst) begin
      standby_reg <= 1'b1;
      sda_out_reg <= 1'b0;
    end else begin
      standby_reg <= (state_reg == ST_IDLE) && !busy_reg && !prog_start_reg;
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign standby = standby_reg;
  assign prog_busy = busy_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_busy_silent: assert property (
    busy_reg |-> !sda_oe_reg && state_reg == ST_IDLE)
    else $error("bus driven while programming");

  chk_oe_after_fall: assert property (
    $changed(sda_oe_reg) |-> $past(scl_fall) || $past(busy_reg) ||
                             $past(evt_start) || $past(evt_stop))
    else $error("sda drive changed outside a falling scl edge");

  chk_ack_on_match: assert property (
    (!busy_reg && !evt_start && !evt_stop && scl_rise && state_reg == ST_DEV &&
     bit_cnt_reg == LAST_BIT && dev_match)
    |=> state_reg == ST_ACK && rw_reg == $past(link_bit_reg))
    else $error("matching address not acknowledged");

  chk_mismatch_idle: assert property (
    (!busy_reg && !evt_start && !evt_stop && scl_rise && state_reg == ST_DEV &&
     bit_cnt_reg == LAST_BIT && !dev_match)
    |=> state_reg == ST_IDLE ##1 !sda_oe_reg)
    else $error("mismatching address not dropped");

  chk_prog_start: assert property (
    (evt_stop && !busy_reg) |=> prog_start_reg == $past(prog_ok) ##1
                                busy_reg == $past(prog_ok, 2))
    else $error("programming start does not follow stop and inhibit");

  chk_prog_bound: assert property (
    $fell(busy_reg) |-> $past(prog_cnt_reg) == 32'(PROG_LEN - 1))
    else $error("programming length wrong");

  chk_page_wrap: assert property (
    (!busy_reg && !evt_start && !evt_stop && scl_rise && state_reg == ST_RX &&
     bit_cnt_reg == LAST_BIT && byte_idx_reg == IDX_DATA)
    |=> addr_cnt_reg[ADDR_W-1:PAGE_OFF_W] == $past(addr_cnt_reg[ADDR_W-1:PAGE_OFF_W]) &&
        addr_cnt_reg[PAGE_OFF_W-1:0] == page_off_reg)
    else $error("page address not held or offset not advanced");

  chk_read_incr: assert property (
    (!busy_reg && !evt_start && !evt_stop && scl_fall && state_reg == ST_TX_ACK && load_reg)
    |=> addr_cnt_reg == $past(addr_cnt_reg) + 1'b1 && state_reg == ST_TX)
    else $error("read address counter not advanced");

  chk_standby_read: assert property (
    (evt_stop && !busy_reg && !prog_ok) |=> ##1 standby_reg)
    else $error("no standby after read stop");

  // the line must already be free when the controller ends a read
  chk_wait_released: assert property (
    state_reg == ST_WAIT |-> !sda_oe_reg)
    else $error("sda still driven after read ended");

  cov_page_write: cover property (
    prog_start_reg && page_mask_reg == '1);
  cov_seq_read: cover property (
    state_reg == ST_TX_ACK && load_reg && scl_fall);
  cov_poll_refused: cover property (
    busy_reg && evt_start);
  cov_inhibit_drop: cover property (
    evt_stop && data_seen_reg && sync2_reg.inhibit);

endmodule // ee_slave

// ---- tb/ee_ctl_model.sv ----
// bus controller model driving the two-wire clock and data lines
`timescale 1ns/100ps
module ee_ctl_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // clock stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #31.2 sda_low = 1'b0;
    #31.3 scl = 1'b1;
    #62.5 sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask

  task automatic stop();
    #31.2 sda_low = 1'b1;
    #31.3 scl = 1'b1;
    #62.5 sda_low = 1'b0;
    #62.5;
  endtask

  // data moves only in mid-low, sampled in mid-high
  task automatic bit_io(input logic b, output logic r);
    #31.2 sda_low = ~b;
    #31.3 scl = 1'b1;
    #31.2 r = sda;
    #31.3 scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule // ee_ctl_model

// ---- tb/testbench.sv ----
// self-checking bench for the serial memory slave
`timescale 1ns/100ps
module testbench;
  import ee_pkg::*;
  localparam int PLEN = 400;
  localparam logic [2:0] STR = 3'h5;
  logic clock;
  logic rst;
  logic [2:0] straps;
  logic inhibit;
  logic sda_oe;
  logic sda_out;
  logic standby;
  logic prog_busy;
  logic scl;
  logic ctl_low;
  logic sda_line;
  logic ak;
  logic [7:0] rd;
  int n_mismatch;
  int n_tests;
  int cyc;

  // open-drain wire with pull-up
  assign sda_line = ctl_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

  ee_slave #(.ADDR_W(ADDR_W_LARGE), .PROG_LEN(PLEN)) uut (
    .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_straps(straps), .prog_inhibit(inhibit),
    .standby(standby), .prog_busy(prog_busy));

  ee_ctl_model ctl (.scl(scl), .sda_low(ctl_low), .sda(sda_line));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic probe(input logic [7:0] w, input logic e);
    ctl.start();
    ctl.send(w, ak);
    chk(ak, {7'h0, e});
    ctl.stop();
  endtask

  task automatic addr_ph(input logic [15:0] a);
    ctl.start();
    ctl.send({DEV_TYPE, STR, 1'b0}, ak);
    chk(ak, 8'h01);
    ctl.send(a[15:8], ak);
    chk(ak, 8'h01);
    ctl.send(a[7:0], ak);
    chk(ak, 8'h01);
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  // n bytes base+i from address a, then the self-timed cycle
  task automatic pw(input logic [15:0] a, input int n, input logic [7:0] b, input logic poll);
    int k;
    addr_ph(a);
    for (int i = 0; i < n; i++) begin
      ctl.send(b + 8'(i), ak);
      chk(ak, 8'h01);
    end
    ctl.stop();
    if (poll) probe({DEV_TYPE, STR, 1'b0}, 1'b0);
    settle();
    chk(prog_busy, 8'h01);
    chk(standby, 8'h00);
    k = 0;
    while (prog_busy === 1'b1 && k < PLEN + 10) begin
      @(posedge clock);
      k++;
    end
    chk(prog_busy, 8'h00);
    settle();
    chk(standby, 8'h01);
    if (poll) probe({DEV_TYPE, STR, 1'b0}, 1'b1);
  endtask

  // dummy write, repeated start, two bytes read
  task automatic rd_seq(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    addr_ph(a);
    ctl.start();
    ctl.send({DEV_TYPE, STR, 1'b1}, ak);
    chk(ak, 8'h01);
    ctl.recv(1'b1, rd);
    chk(rd, e0);
    ctl.recv(1'b0, rd);
    chk(rd, e1);
    ctl.stop();
    settle();
    chk(prog_busy, 8'h00);
    chk(standby, 8'h01);
    chk(sda_out, 8'h00);
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    straps = STR;
    inhibit = 1'b0;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    settle();
    chk(standby, 8'h01);
    chk(prog_busy, 8'h00);
    probe({4'hb, STR, 1'b0}, 1'b0);
    probe({DEV_TYPE, 3'h2, 1'b0}, 1'b0);
    pw(16'h1234, 2, 8'h5a, 1'b1);
    rd_seq(16'h1234, 8'h5a, 8'h5b);
    // top address bit lies beyond the array and must not matter
    rd_seq(16'h9234, 8'h5a, 8'h5b);
    // 66 bytes from offset 3e roll over inside the page
    pw(16'h0a3e, 66, 8'h80, 1'b0);
    rd_seq(16'h0a3e, 8'hc0, 8'hc1);
    rd_seq(16'h0a00, 8'h82, 8'h83);
    @(posedge clock);
    #1 inhibit = 1'b1;
    addr_ph(16'h1234);
    ctl.send(8'hee, ak);
    chk(ak, 8'h01);
    ctl.stop();
    settle();
    chk(prog_busy, 8'h00);
    rd_seq(16'h1234, 8'h5a, 8'h5b);
    @(posedge clock);
    #1 inhibit = 1'b0;
    addr_ph(16'h1234);
    ctl.stop();
    settle();
    chk(prog_busy, 8'h00);
    pw(16'h7fff, 1, 8'h11, 1'b0);
    pw(16'h0000, 1, 8'h22, 1'b0);
    rd_seq(16'h7fff, 8'h11, 8'h22);
    report_and_stop();
  end
endmodule // testbench
